// ==== common/dam_pkg.sv ====
// constants, register map and state type of the drive attenuator / meter mode block
// assumes a 125 MHz system clock and classic wishbone register access
package dam_pkg;
    // clock and tick timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // delay intervals in their own unit
    localparam int INSERT_DELAY_MS = 500;
    localparam int RELEASE_DELAY_MS = 5000;
    localparam int TIMER_W = 13;
    localparam int DIV_W = 17;
    localparam logic [TIMER_W-1:0] INSERT_TICKS = TIMER_W'(INSERT_DELAY_MS / TICK_PERIOD_MS);
    localparam logic [TIMER_W-1:0] RELEASE_TICKS = TIMER_W'(RELEASE_DELAY_MS / TICK_PERIOD_MS);
    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    // control register fields and reset value
    localparam int CTRL_CHOICE_BIT = 0;
    localparam int CTRL_ISOLATE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_HIGH_BIT = 2;
    localparam int STAT_LOW_BIT = 3;
    localparam int STAT_MEAN_BIT = 4;
    localparam int STAT_PIN_LSB = 5;
    // synchronised pin indices
    localparam int PIN_UPPER = 0;
    localparam int PIN_LOWER = 1;
    localparam int PIN_TUNE_CMD = 2;
    localparam int PIN_TUNE_STATE = 3;
    localparam int PIN_REMOTE_N = 4;
    localparam int PIN_METER_SEL = 5;
    localparam int PIN_COUNT = 6;
    // insertion states, gray along idle-arm-insert-release
    typedef enum logic [1:0] {
        DAM_IDLE = 2'h0,
        DAM_ARMING = 2'h1,
        DAM_INSERTED = 2'h3,
        DAM_RELEASING = 2'h2
    } dam_state_t;
endpackage

// ==== common/dam_timer_if.sv ====
// link between the insertion state machine and its delay timer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface dam_timer_if;
    logic start; // clears and runs the timer
    logic [12:0] target; // interval in ticks
    logic done; // high in the last cycle of the interval
    modport ctrl(output start, output target, input done);
    modport timer(input start, input target, output done);
endinterface

// ==== design/dam_delay_timer.sv ====
// tick divider plus tick counter that marks the end of a delay interval
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module dam_delay_timer import dam_pkg::*; #(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    dam_timer_if.timer tmr
);
    logic [DIV_W-1:0] divReg, divNext; // cycles within a tick
    logic [TIMER_W-1:0] tickReg, tickNext; // whole ticks elapsed
    logic runReg, runNext; // counting since first start
    logic wrap; // last cycle of a tick

    assign wrap = (divReg == DIV_W'(TICK_CYCLES_P - 1));
    // done is exact to the cycle: interval = target * tick length
    assign tmr.done = runReg && wrap && (tickReg == tmr.target - TIMER_W'(1));

    // next counter values
    always_comb begin
        divNext = divReg;
        tickNext = tickReg;
        runNext = runReg;
        if (tmr.start) begin
            divNext = '0;
            tickNext = '0;
            runNext = 1'b1;
        end else if (runReg) begin
            if (wrap) begin
                divNext = '0;
                tickNext = tickReg + TIMER_W'(1);
            end else begin
                divNext = divReg + DIV_W'(1);
            end
        end
    end

    // counter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            divReg <= '0;
            tickReg <= '0;
            runReg <= 1'b0;
        end else begin
            divReg <= divNext;
            tickReg <= tickNext;
            runReg <= runNext;
        end
    end
endmodule

// ==== design/dam_attn_meter_ctrl.sv ====
// drive attenuator insertion control and meter mean/peak selection
// assumes detector outputs and control pins are asynchronous levels,
// and a classic wishbone master on the system clock
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - insert relay 0.5 s after upper detection
// - control bit picks high or low rating relay
// - relay held until lower detector reports
// - release relay about 5 s after low
// - tune command clears insertion state at once
// - isolate bit disables insertion by blanking input
// - remote, tuned, select low: mean output, indicator
// - remote, tuned, select high: peak output, indicator
// - local mode ignores remote meter select
// - local mode picks peak once tuned
// - tune state high forces mean metering
module dam_attn_meter_ctrl import dam_pkg::*; #(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic upperLevelDetector,
    input wire logic lowerLevelDetector,
    input wire logic tuneCommandIn,
    input wire logic tuneStateIn,
    input wire logic remoteModeInN,
    input wire logic remoteMeterSelectIn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic attnRelayHighRating,
    output logic attnRelayLowRating,
    output logic meterMeanSelectOut,
    output logic meanIndicator,
    output logic peakIndicator
);
    // relay energised in this state
    function automatic logic relayOn(input dam_state_t s);
        relayOn = (s == DAM_INSERTED) || (s == DAM_RELEASING);
    endfunction

    // pin synchroniser stages
    logic [PIN_COUNT-1:0] pinRaw; // gathered asynchronous pins
    logic [PIN_COUNT-1:0] syncA_reg, syncA_next; // first stage, read by second only
    logic [PIN_COUNT-1:0] syncB_reg, syncB_next; // second stage, safe to use

    // insertion state
    dam_state_t state_reg, state_next;
    logic highRelay_reg, highRelay_next;
    logic lowRelay_reg, lowRelay_next;

    // meter selection state
    logic meanSel_reg, meanSel_next;
    logic meanInd_reg, meanInd_next;
    logic peakInd_reg, peakInd_next;

    // register file and bus
    logic [1:0] ctrl_reg, ctrl_next; // relay choice and isolate bits
    logic ack_reg, ack_next;
    logic [31:0] rdData_reg, rdData_next;
    logic reqValid; // new bus request this cycle

    // qualified detector levels
    logic upperQ, lowQ, tuneCmd, isolate, choiceHigh;

    dam_timer_if tmrIf();

    // one shared timer for both delays
    dam_delay_timer #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) uTimer (
        .clk(clk),
        .rst(rst),
        .tmr(tmrIf)
    );

    assign pinRaw = {remoteMeterSelectIn, remoteModeInN, tuneStateIn,
                     tuneCommandIn, lowerLevelDetector, upperLevelDetector};

    // synchroniser next values
    always_comb begin
        syncA_next = pinRaw;
        syncB_next = syncA_reg;
    end

    // synchroniser registers
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
        end
    end

    assign isolate = ctrl_reg[CTRL_ISOLATE_BIT];
    assign choiceHigh = ctrl_reg[CTRL_CHOICE_BIT];
    // isolation makes the sensed level read as zero current
    assign upperQ = syncB_reg[PIN_UPPER] & ~isolate;
    assign lowQ = syncB_reg[PIN_LOWER] | isolate;
    assign tuneCmd = syncB_reg[PIN_TUNE_CMD];
    // interval chosen by the running phase
    assign tmrIf.target = (state_reg == DAM_RELEASING) ? RELEASE_TICKS : INSERT_TICKS;

    // insertion state machine next values
    always_comb begin
        state_next = state_reg;
        tmrIf.start = 1'b0;
        case (state_reg)
            // waiting for overload
            DAM_IDLE: begin
                if (upperQ) begin
                    state_next = DAM_ARMING;
                    tmrIf.start = 1'b1;
                end
            end
            // insert delay runs regardless of the level
            DAM_ARMING: begin
                if (tmrIf.done) begin
                    state_next = DAM_INSERTED;
                end
            end
            // hold until level drops
            DAM_INSERTED: begin
                if (lowQ && !upperQ) begin
                    state_next = DAM_RELEASING;
                    tmrIf.start = 1'b1;
                end
            end
            // release delay, cancelled by a new overload
            DAM_RELEASING: begin
                if (upperQ) begin
                    state_next = DAM_INSERTED;
                end else if (tmrIf.done) begin
                    state_next = DAM_IDLE;
                end
            end
            default: begin
                state_next = DAM_IDLE;
            end
        endcase
        // tune command wins over everything
        if (tuneCmd) begin
            state_next = DAM_IDLE;
            tmrIf.start = 1'b0;
        end
        // relays follow the next state so they leave a flop
        highRelay_next = relayOn(state_next) && choiceHigh;
        lowRelay_next = relayOn(state_next) && !choiceHigh;
    end

    // insertion registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= DAM_IDLE;
            highRelay_reg <= 1'b0;
            lowRelay_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            highRelay_reg <= highRelay_next;
            lowRelay_reg <= lowRelay_next;
        end
    end

    // meter mode next values
    always_comb begin
        if (syncB_reg[PIN_TUNE_STATE]) begin
            meanSel_next = 1'b1;
        end else if (!syncB_reg[PIN_REMOTE_N]) begin
            // remote: low select means mean
            meanSel_next = !syncB_reg[PIN_METER_SEL];
        end else begin
            // local: select pin not looked at
            meanSel_next = 1'b0;
        end
        meanInd_next = meanSel_next;
        peakInd_next = !meanSel_next;
    end

    // meter mode registers
    always_ff @(posedge clk) begin
        if (rst) begin
            meanSel_reg <= 1'b1;
            meanInd_reg <= 1'b1;
            peakInd_reg <= 1'b0;
        end else begin
            meanSel_reg <= meanSel_next;
            meanInd_reg <= meanInd_next;
            peakInd_reg <= peakInd_next;
        end
    end

    assign reqValid = wb_cyc_i && wb_stb_i && !ack_reg;

    // bus slave next values: answer one cycle after the request
    always_comb begin
        ack_next = reqValid;
        ctrl_next = ctrl_reg;
        rdData_next = 32'h0;
        if (reqValid && wb_we_i && wb_sel_i[0] && (wb_adr_i == CTRL_OFFSET)) begin
            ctrl_next = wb_dat_i[1:0];
        end
        if (reqValid && !wb_we_i) begin
            case (wb_adr_i)
                // control readback
                CTRL_OFFSET: begin
                    rdData_next[1:0] = ctrl_reg;
                end
                // live block state
                STATUS_OFFSET: begin
                    rdData_next[STAT_STATE_LSB +: 2] = state_reg;
                    rdData_next[STAT_HIGH_BIT] = highRelay_reg;
                    rdData_next[STAT_LOW_BIT] = lowRelay_reg;
                    rdData_next[STAT_MEAN_BIT] = meanSel_reg;
                    rdData_next[STAT_PIN_LSB +: PIN_COUNT] = syncB_reg;
                end
                // unmapped reads as zero
                default: begin
                    rdData_next = 32'h0;
                end
            endcase
        end
    end

    // bus slave registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            rdData_reg <= 32'h0;
        end else begin
            ack_reg <= ack_next;
            ctrl_reg <= ctrl_next;
            rdData_reg <= rdData_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;
    assign attnRelayHighRating = highRelay_reg;
    assign attnRelayLowRating = lowRelay_reg;
    assign meterMeanSelectOut = meanSel_reg;
    assign meanIndicator = meanInd_reg;
    assign peakIndicator = peakInd_reg;

    // checks on the insertion, meter and bus logic
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_tune_clears_relays: assert property (tuneCmd |=> !attnRelayHighRating && !attnRelayLowRating)
        else $error("relay energised during tune command");
    a_arm_holds_wait: assert property (state_reg == DAM_ARMING && !tmrIf.done && !tuneCmd
        |=> state_reg == DAM_ARMING && !attnRelayHighRating && !attnRelayLowRating)
        else $error("relay inserted before delay ended");
    a_insert_on_done: assert property (state_reg == DAM_ARMING && tmrIf.done && !tuneCmd
        |=> (attnRelayHighRating || attnRelayLowRating) && state_reg == DAM_INSERTED)
        else $error("relay not inserted at end of delay");
    a_relay_choice_one: assert property (relayOn(state_reg)
        |-> (attnRelayHighRating != attnRelayLowRating))
        else $error("not exactly one relay energised");
    a_inserted_holds: assert property (state_reg == DAM_INSERTED && !lowQ && !tuneCmd
        |=> state_reg == DAM_INSERTED)
        else $error("relay left before lower detection");
    a_release_done: assert property (state_reg == DAM_RELEASING && tmrIf.done && !upperQ && !tuneCmd
        |=> state_reg == DAM_IDLE ##1 !attnRelayHighRating && !attnRelayLowRating)
        else $error("relay not released after delay");
    a_isolate_blocks: assert property (isolate && state_reg == DAM_IDLE |=> state_reg == DAM_IDLE)
        else $error("insertion started while isolated");
    a_cancel_release: assert property (state_reg == DAM_RELEASING && upperQ && !tuneCmd
        |=> state_reg == DAM_INSERTED)
        else $error("release not cancelled by overload");
    a_remote_mean_sel: assert property (!syncB_reg[PIN_TUNE_STATE] && !syncB_reg[PIN_REMOTE_N]
        && !syncB_reg[PIN_METER_SEL] |=> meterMeanSelectOut && meanIndicator && !peakIndicator)
        else $error("remote mean selection not applied");
    a_remote_peak_sel: assert property (!syncB_reg[PIN_TUNE_STATE] && !syncB_reg[PIN_REMOTE_N]
        && syncB_reg[PIN_METER_SEL] |=> !meterMeanSelectOut && peakIndicator && !meanIndicator)
        else $error("remote peak selection not applied");
    a_local_peak_sel: assert property (!syncB_reg[PIN_TUNE_STATE] && syncB_reg[PIN_REMOTE_N]
        |=> !meterMeanSelectOut && peakIndicator)
        else $error("local mode not peak");
    a_tune_forces_mean: assert property ($rose(syncB_reg[PIN_TUNE_STATE])
        |=> meterMeanSelectOut [*2])
        else $error("tuning did not force mean");
    a_bus_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_insert_seen: cover property (state_reg == DAM_ARMING ##1 state_reg == DAM_INSERTED);
    c_release_seen: cover property (state_reg == DAM_RELEASING ##1 state_reg == DAM_IDLE);
    c_cancel_seen: cover property (state_reg == DAM_RELEASING ##1 state_reg == DAM_INSERTED);
    c_remote_peak: cover property (!syncB_reg[PIN_REMOTE_N] && !meterMeanSelectOut);
endmodule

// ==== sim/dam_far_side_model.sv ====
// far side: level detectors, tuning controller and remote control lines
// assumes the bench sets the wanted levels just after a rising clock edge
`timescale 1ns/1ps
module dam_far_side_model (
    input wire logic clk,
    input wire logic [1:0] level, // cathode level: 0 low, 1 mid, 2 high
    input wire logic tuning, // transmitter busy tuning
    input wire logic tuneCmd, // tune sequence requested
    input wire logic remote, // extended remote operation wanted
    input wire logic meterSel, // remote choice: 0 mean, 1 peak
    output logic upperLevelDetector,
    output logic lowerLevelDetector,
    output logic tuneCommandIn,
    output logic tuneStateIn,
    output logic remoteModeInN,
    output logic remoteMeterSelectIn
);
    // quiet levels before the first edge: low level, local, tuned
    initial begin
        {upperLevelDetector, lowerLevelDetector, tuneCommandIn} = 3'h2;
        {tuneStateIn, remoteModeInN, remoteMeterSelectIn} = 3'h2;
    end

    // every line follows its request one clock later
    always @(posedge clk) begin
        upperLevelDetector <= (level == 2'h2);
        lowerLevelDetector <= (level == 2'h0);
        tuneCommandIn <= tuneCmd;
        tuneStateIn <= tuning;
        remoteModeInN <= ~remote;
        remoteMeterSelectIn <= meterSel;
    end
endmodule

// ==== sim/dam_attn_meter_ctrl_test.sv ====
// self-checking bench for the attenuator and meter mode block
// assumes a short tick of 4 clocks so the delays run 2000 and 20000 clocks
`timescale 1ns/1ps
module dam_attn_meter_ctrl_test;
    localparam int TK = 4; // clocks per tick
    typedef struct packed {logic [1:0] val; int cyc;} dam_rel_t; // relay pair and due cycle
    logic clk = 1'b0, rst = 1'b1;
    logic [1:0] level = 2'h0;
    logic tuning = 1'b0, tuneCmd = 1'b0, remote = 1'b0, meterSel = 1'b0;
    logic upper, lower, tcmd, tstate, remN, msel;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] datI = 32'h0, datO;
    logic relHigh, relLow, meanSel, meanInd, peakInd, expMean;
    logic [1:0] prevRel = 2'h0; // relay pair seen at the last edge
    logic [31:0] rdQ[$]; // expected read data
    dam_rel_t relQ[$]; // expected relay changes
    dam_rel_t e;
    int err_count = 0, compares = 0, cycle = 0, seed = 28, r, j;

    // clock of 8 ns
    initial begin
        forever #4 clk = ~clk;
    end

    dam_far_side_model far (.clk(clk), .level(level), .tuning(tuning), .tuneCmd(tuneCmd), .remote(remote),
        .meterSel(meterSel), .upperLevelDetector(upper), .lowerLevelDetector(lower), .tuneCommandIn(tcmd),
        .tuneStateIn(tstate), .remoteModeInN(remN), .remoteMeterSelectIn(msel));

    dam_attn_meter_ctrl #(.TICK_CYCLES_P(TK)) uut (.clk(clk), .rst(rst), .upperLevelDetector(upper),
        .lowerLevelDetector(lower), .tuneCommandIn(tcmd), .tuneStateIn(tstate), .remoteModeInN(remN),
        .remoteMeterSelectIn(msel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .attnRelayHighRating(relHigh),
        .attnRelayLowRating(relLow), .meterMeanSelectOut(meanSel), .meanIndicator(meanInd),
        .peakIndicator(peakInd));

    // one comparison, counted
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single bus cycle; a read notes its expected data first
    task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d, input logic [31:0] x);
        if (!w) rdQ.push_back(x);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        datI <= d;
        // wait as long as the slave takes; a lost answer is ended by the hang guard
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // note a relay change due so many cycles from now
    task expect_rel(input logic [1:0] v, input int dly);
        relQ.push_back('{v, cycle + dly});
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // read data checked at the acking edge against the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (rdQ.size() == 0) begin
                err_count++;
                $display("BAD %0t read answered with nothing expected", $time);
            end else check(datO, rdQ.pop_front());
        end
    end

    // relay changes checked for value and for arrival within a few clocks of due
    always @(posedge clk) begin
        cycle++;
        if (rst === 1'b0 && {relHigh, relLow} !== prevRel) begin
            if (relQ.size() == 0) check({30'h0, relHigh, relLow}, 32'hff);
            else begin
                e = relQ.pop_front();
                check({30'h0, relHigh, relLow}, {30'h0, e.val});
                check(32'((cycle - e.cyc) >= 0 && (cycle - e.cyc) <= 6), 32'h1);
            end
        end
        prevRel = {relHigh, relLow};
    end

    // hang guard
    initial begin
        #800000;
        $display("BAD %0t run did not finish", $time);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // register reset values, unmapped place, disabled byte lane
        wb(1'b0, 4'h0, 4'hf, 32'h0, 32'h1);
        wb(1'b0, 4'h4, 4'hf, 32'h0, 32'h240);
        r = $random(seed);
        wb(1'b1, 4'h8, 4'hf, r, 32'h0);
        wb(1'b0, 4'h8, 4'hf, 32'h0, 32'h0);
        wb(1'b1, 4'h0, 4'he, 32'h2, 32'h0);
        wb(1'b0, 4'h0, 4'hf, 32'h0, 32'h1);
        $display("test registers done");
        // meter mode over every tune, mode and selection
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            tuning <= i[0];
            remote <= i[1];
            meterSel <= (i < 8) ? i[2] : r[0];
            repeat (6) @(posedge clk);
            expMean = tuning | (remote & ~meterSel);
            check(meanSel, expMean);
            check(meanInd, expMean);
            check(peakInd, !expMean);
        end
        tuning <= 1'b0;
        remote <= 1'b0;
        $display("test meter done");
        // insert high rating, hold at mid level, release after low
        level <= 2'h2;
        expect_rel(2'h2, 500 * TK);
        repeat (2100) @(posedge clk);
        level <= 2'h1;
        repeat (1000) @(posedge clk);
        level <= 2'h0;
        expect_rel(2'h0, 5000 * TK);
        repeat (20100) @(posedge clk);
        $display("test insert release done");
        // low rating, release cancelled by upper level, then tune clears
        wb(1'b1, 4'h0, 4'h1, 32'h0, 32'h0);
        level <= 2'h2;
        expect_rel(2'h1, 500 * TK);
        repeat (2100) @(posedge clk);
        level <= 2'h0;
        repeat (10000) @(posedge clk);
        level <= 2'h2;
        repeat (10) @(posedge clk);
        level <= 2'h1;
        repeat (21000) @(posedge clk);
        tuneCmd <= 1'b1;
        expect_rel(2'h0, 0);
        repeat (20) @(posedge clk);
        tuneCmd <= 1'b0;
        level <= 2'h0;
        $display("test cancel and tune done");
        // insertion blocked by isolation, then by a held tune command
        for (j = 0; j < 2; j++) begin
            if (j == 0) wb(1'b1, 4'h0, 4'h1, 32'h3, 32'h0);
            else tuneCmd <= 1'b1;
            level <= 2'h2;
            repeat (2100) @(posedge clk);
            level <= 2'h0;
            tuneCmd <= 1'b0;
            // let the dropped level pass the synchroniser before isolation lifts
            repeat (10) @(posedge clk);
            wb(1'b1, 4'h0, 4'h1, 32'h1, 32'h0);
        end
        check(32'(relQ.size()), 32'h0);
        $display("test blocked insertion done");
        end_of_test();
    end
endmodule
